// [logic/disp_bus_if.sv]
`timescale 1ns/1ps
interface disp_bus_if;
  logic chip_enable_n;
  logic register_select;
  logic blank_input;
  logic disp_reset_n;
  logic serial_clk;
  logic serial_data;
  logic data_out;

  modport host
  (
    output chip_enable_n, register_select, blank_input, disp_reset_n,
    output serial_clk, serial_data,
    input  data_out
  );
  modport display
  (
    input  chip_enable_n, register_select, blank_input, disp_reset_n,
    input  serial_clk, serial_data,
    output data_out
  );
endinterface

// [logic/disp_pkg.sv]
package disp_pkg;

  // ----------------------------------------------------------------
  // Display organisation
  // ----------------------------------------------------------------
  localparam int N_IC    = 2;
  localparam int IC_BITS = 160;
  localparam int COLS    = 20;
  localparam int ROWS    = 8;
  localparam int CW_W    = 8;

  // ----------------------------------------------------------------
  // Refresh timing, in display clock cycles
  // ----------------------------------------------------------------
  localparam logic [5:0] ROW_LAST  = 6'h3f;  // 64 cycles per row
  localparam logic [5:0] BLANK_CYC = 6'h04;  // Blank before each row
  localparam logic [5:0] MAX_ON    = 6'h3c;  // 60 cycles at most
  localparam logic [2:0] PRE_LAST  = 3'h7;   // Divide by eight

  // PWM code to enabled cycles per row
  localparam logic [5:0] PWM_ON [16] = '{
    6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h0a,
    6'h0d, 6'h10, 6'h14, 6'h18, 6'h1e, 6'h24, 6'h30, 6'h3c};
  // Peak current code to percent of full scale
  localparam logic [6:0] PEAK_PCT [4] = '{7'h49, 7'h32, 7'h1f, 7'h64};

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int CW_SEL_BIT    = 7;
  localparam int CW_PWM_LSB    = 0;
  localparam int CW_PEAK_LSB   = 4;
  localparam int CW_NORMAL_BIT = 6;
  localparam int CW1_SIMUL_BIT = 0;
  localparam int CW1_PRE_BIT   = 1;

  // ----------------------------------------------------------------
  // Pin sampling order in the display synchroniser
  // ----------------------------------------------------------------
  localparam int PIN_CE_N  = 0;
  localparam int PIN_RS    = 1;
  localparam int PIN_BL    = 2;
  localparam int PIN_RST_N = 3;
  localparam int PIN_SCLK  = 4;
  localparam int PIN_SDATA = 5;
  localparam int PIN_OSC   = 6;
  localparam int PIN_N     = 7;

  // ----------------------------------------------------------------
  // Clock and time constants
  // ----------------------------------------------------------------
  localparam int CLK_MHZ  = 100;
  localparam int HALF_NS  = 50;    // Serial clock half period
  localparam int HALF_CYC = (HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int OSC_NS   = 2000;  // Internal oscillator period
  localparam int OSC_CYC  = OSC_NS * CLK_MHZ / 1000;

  // ----------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_COUNT  = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam int CTRL_GO    = 0;
  localparam int CTRL_RS    = 1;
  localparam int CTRL_BLANK = 2;
  localparam int CTRL_RESET = 3;
  localparam int ST_BUSY    = 0;
  localparam int ST_FULL    = 1;
  localparam int ST_EMPTY   = 2;
  localparam int ST_DOUT    = 3;
  localparam int CNT_W      = 9;
  localparam logic [5:0] WORD_BITS = 6'h20;

endpackage

// [logic/display_end.sv]
`timescale 1ns/1ps
module display_end #(
  parameter int N_IC    = disp_pkg::N_IC,
  parameter int OSC_CYC = disp_pkg::OSC_CYC
) (
  // Clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   clk_en,
  // Serial bus from the host
  disp_bus_if.display                 bus,
  // Oscillator
  input  wire logic                   osc_ext_in,
  input  wire logic                   osc_use_ext,
  output logic                        osc_out,
  // LED drivers
  output logic [N_IC*disp_pkg::ROWS-1:0] row_drive,
  output logic [N_IC*disp_pkg::COLS-1:0] col_drive,
  output logic [N_IC*2-1:0]           peak_code,
  output logic [N_IC*7-1:0]           brightness_pct
);
  localparam int DOT_W = N_IC * disp_pkg::IC_BITS;
  localparam int OW    = $clog2(OSC_CYC);
  localparam int RW    = N_IC * disp_pkg::ROWS;
  localparam int CWW   = N_IC * disp_pkg::COLS;

  if (N_IC < 1 || OSC_CYC < 2)
  begin : g_bad
    $error("display_end needs one IC and an oscillator of two cycles");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [disp_pkg::PIN_N-1:0] sync1;
    logic [disp_pkg::PIN_N-1:0] sync2;
    logic                       sclk_prev;
    logic                       ce_n_prev;
    logic                       osc_prev;
    logic                       sel_ctrl;
    logic                       load_pend;
    logic [DOT_W-1:0]           dot_sr;
    logic [DOT_W-1:0]           dot_lat;
    logic [N_IC-1:0][7:0]       ctl_sr;
    logic [N_IC-1:0][6:0]       cw0;
    logic [N_IC-1:0][6:0]       cw1;
    logic [OW-1:0]              osc_cnt;
    logic [2:0]                 pre_cnt;
    logic [2:0]                 row;
    logic [5:0]                 col;
    logic                       osc_out;
    logic                       data_out;
    logic [RW-1:0]              row_drive;
    logic [CWW-1:0]             col_drive;
    logic [N_IC*2-1:0]          peak_code;
    logic [N_IC*7-1:0]          bright;
  } disp_state_t;

  disp_state_t q;
  disp_state_t d;
  logic        ce_n;
  logic        sclk;
  logic        sdata;
  logic        cin;
  logic        awake;
  logic        tick;
  logic        lit;
  logic [5:0]  on_cyc;
  logic [12:0] prod;

  assign osc_out        = q.osc_out;
  assign row_drive      = q.row_drive;
  assign col_drive      = q.col_drive;
  assign peak_code      = q.peak_code;
  assign brightness_pct = q.bright;
  assign bus.data_out   = q.data_out;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    // Two stages for every pin; only stage two is read
    d.sync1 = {osc_ext_in, bus.serial_data, bus.serial_clk, bus.disp_reset_n,
               bus.blank_input, bus.register_select, bus.chip_enable_n};
    d.sync2 = q.sync1;
    ce_n    = q.sync2[disp_pkg::PIN_CE_N];
    sclk    = q.sync2[disp_pkg::PIN_SCLK];
    sdata   = q.sync2[disp_pkg::PIN_SDATA];
    d.sclk_prev = sclk;
    d.ce_n_prev = ce_n;
    d.osc_prev  = q.sync2[disp_pkg::PIN_OSC];
    cin   = sdata;
    tick  = 1'b0;
    lit   = 1'b0;
    on_cyc = '0;
    prod   = '0;
    awake  = 1'b0;

    // Falling chip enable picks dot or control register
    if (q.ce_n_prev && !ce_n)
    begin
      d.sel_ctrl  = q.sync2[disp_pkg::PIN_RS];
      d.load_pend = 1'b1;
    end
    // Rising serial clock under chip enable shifts one bit
    if (!ce_n && sclk && !q.sclk_prev)
    begin
      if (q.sel_ctrl)
      begin
        for (int i = 0; i < N_IC; i++)
        begin
          d.ctl_sr[i] = {q.ctl_sr[i][6:0], cin};
          cin = q.cw1[i][disp_pkg::CW1_SIMUL_BIT] ? cin : q.ctl_sr[i][7];
        end
        d.data_out = cin;
      end
      else
      begin
        d.dot_sr   = {sdata, q.dot_sr[DOT_W-1:1]};
        d.data_out = q.dot_sr[0];
      end
    end
    // Chip enable high with clock low copies into latch or word
    if (q.load_pend && ce_n && !sclk)
    begin
      d.load_pend = 1'b0;
      if (q.sel_ctrl)
      begin
        for (int i = 0; i < N_IC; i++)
        begin
          if (q.ctl_sr[i][disp_pkg::CW_SEL_BIT])
            d.cw1[i] = q.ctl_sr[i][6:0];
          else
            d.cw0[i] = q.ctl_sr[i][6:0];
        end
      end
      else
      begin
        d.dot_lat = q.dot_sr;
      end
    end
    // Display reset clears control words, so every IC sleeps
    if (!q.sync2[disp_pkg::PIN_RST_N])
    begin
      d.cw0       = '0;
      d.cw1       = '0;
      d.load_pend = 1'b0;
    end

    // Oscillator runs while any IC is awake
    for (int i = 0; i < N_IC; i++)
    begin
      awake = awake | q.cw0[i][disp_pkg::CW_NORMAL_BIT];
    end
    if (osc_use_ext)
    begin
      // Slave or external source, edge of synchronised input
      d.osc_out = 1'b0;
      d.osc_cnt = '0;
      if (q.sync2[disp_pkg::PIN_OSC] && !q.osc_prev && awake)
      begin
        if (q.cw1[0][disp_pkg::CW1_PRE_BIT])
        begin
          d.pre_cnt = q.pre_cnt + 1'b1;
          tick = (q.pre_cnt == disp_pkg::PRE_LAST);
        end
        else
        begin
          tick = 1'b1;
        end
      end
    end
    else if (awake)
    begin
      // Internal oscillator, square wave out for slaves
      tick      = (q.osc_cnt == OW'(OSC_CYC - 1));
      d.osc_cnt = tick ? '0 : q.osc_cnt + 1'b1;
      d.osc_out = (q.osc_cnt < OW'(OSC_CYC / 2));
    end
    else
    begin
      d.osc_out = 1'b0;
    end

    // Refresh counters: 64 cycles per row, eight rows
    if (tick)
    begin
      d.col = q.col + 1'b1;
      if (q.col == disp_pkg::ROW_LAST)
      begin
        d.col = '0;
        d.row = q.row + 1'b1;
      end
    end

    // Row sinks and column sources, one row lit per IC
    for (int i = 0; i < N_IC; i++)
    begin
      on_cyc = disp_pkg::PWM_ON[q.cw0[i][disp_pkg::CW_PWM_LSB +: 4]];
      lit = q.cw0[i][disp_pkg::CW_NORMAL_BIT] && !q.sync2[disp_pkg::PIN_BL]
            && (q.col >= disp_pkg::BLANK_CYC)
            && ((q.col - disp_pkg::BLANK_CYC) < on_cyc);
      for (int r = 0; r < disp_pkg::ROWS; r++)
      begin
        d.row_drive[i*disp_pkg::ROWS + r] = lit && (q.row == 3'(r));
      end
      for (int c = 0; c < disp_pkg::COLS; c++)
      begin
        // IC i owns latch bits from i*160, left IC first
        d.col_drive[i*disp_pkg::COLS + c] = lit &&
          q.dot_lat[i*disp_pkg::IC_BITS + c*disp_pkg::ROWS + int'(q.row)];
      end
      d.peak_code[i*2 +: 2] = q.cw0[i][disp_pkg::CW_PEAK_LSB +: 2];
      // Both factors widened first, or the product keeps only seven bits
      prod = 13'(disp_pkg::PEAK_PCT[q.cw0[i][disp_pkg::CW_PEAK_LSB +: 2]]) * 13'(on_cyc);
      d.bright[i*7 +: 7] = 7'(prod / 13'(disp_pkg::MAX_ON));
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
    end
    else if (clk_en)
    begin
      q <= d;
    end
  end
endmodule // display_end

// [logic/display_host.sv]
`timescale 1ns/1ps
module display_host #(
  parameter int HALF_CYC = disp_pkg::HALF_CYC,
  parameter int DEPTH    = 8
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Serial display bus
  disp_bus_if.host         bus
);
  localparam int TW = $clog2(HALF_CYC + 1);

  if (HALF_CYC < 1)
  begin : g_bad
    $error("display_host needs a half period of one cycle or more");
  end

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_SELECT = 3'b001,
    S_LOW    = 3'b010,
    S_HIGH   = 3'b011,
    S_END    = 3'b100
  } host_st_t;

  typedef struct packed {
    host_st_t                  st;
    logic                      pend_wr;
    logic [7:0]                pend_addr;
    logic                      hready;
    logic [31:0]               hrdata;
    logic                      rs;
    logic                      blank;
    logic                      rst;
    logic [disp_pkg::CNT_W-1:0] count;
    logic [disp_pkg::CNT_W-1:0] left;
    logic [TW-1:0]             timer;
    logic [31:0]               word;
    logic [5:0]                wbits;
    logic                      ce_n;
    logic                      sclk;
    logic                      sdata;
    logic                      dout1;
    logic                      dout2;
  } host_state_t;

  host_state_t q;
  host_state_t d;
  logic        push_valid;
  logic        push_ready;
  logic        pop_valid;
  logic        pop_ready;
  logic [31:0] pop_data;

  assign hreadyout           = q.hready;
  assign hrdata              = q.hrdata;
  assign hresp               = 1'b0;
  assign bus.chip_enable_n   = q.ce_n;
  assign bus.register_select = q.rs;
  assign bus.blank_input     = q.blank;
  assign bus.disp_reset_n    = !q.rst;
  assign bus.serial_clk      = q.sclk;
  assign bus.serial_data     = q.sdata;

  // Data words on their way to the serial shifter
  word_fifo #(
    .WIDTH (32),
    .DEPTH (DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clk_en    (clk_en),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (hwdata),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  // Bus decode, register writes and serial sequencer
  always_comb
  begin
    d          = q;
    push_valid = 1'b0;
    pop_ready  = 1'b0;
    d.dout1    = bus.data_out;
    d.dout2    = q.dout1;
    // Data phase of a pending write
    if (q.pend_wr)
    begin
      if (q.pend_addr == disp_pkg::REG_DATA)
      begin
        push_valid = 1'b1;
        if (push_ready)
        begin
          d.pend_wr = 1'b0;
          d.hready  = 1'b1;
        end
      end
      else
      begin
        d.pend_wr = 1'b0;
        if (q.pend_addr == disp_pkg::REG_CTRL)
        begin
          d.rs    = hwdata[disp_pkg::CTRL_RS];
          d.blank = hwdata[disp_pkg::CTRL_BLANK];
          d.rst   = hwdata[disp_pkg::CTRL_RESET];
          if (hwdata[disp_pkg::CTRL_GO] && q.st == S_IDLE && q.count != '0)
          begin
            d.st    = S_SELECT;
            d.left  = q.count;
            d.timer = TW'(HALF_CYC);
          end
        end
        else if (q.pend_addr == disp_pkg::REG_COUNT)
        begin
          d.count = hwdata[disp_pkg::CNT_W-1:0];
        end
      end
    end
    // Address phase
    if (hsel && htrans[1] && hready)
    begin
      d.hrdata = '0;
      if (hwrite)
      begin
        d.pend_wr   = 1'b1;
        d.pend_addr = haddr[7:0];
        d.hready    = (haddr[7:0] != disp_pkg::REG_DATA);
      end
      else if (haddr[7:0] == disp_pkg::REG_CTRL)
      begin
        d.hrdata[disp_pkg::CTRL_RS]    = q.rs;
        d.hrdata[disp_pkg::CTRL_BLANK] = q.blank;
        d.hrdata[disp_pkg::CTRL_RESET] = q.rst;
      end
      else if (haddr[7:0] == disp_pkg::REG_COUNT)
      begin
        d.hrdata[disp_pkg::CNT_W-1:0] = q.count;
      end
      else if (haddr[7:0] == disp_pkg::REG_STATUS)
      begin
        d.hrdata[disp_pkg::ST_BUSY]  = (q.st != S_IDLE);
        d.hrdata[disp_pkg::ST_FULL]  = !push_ready;
        d.hrdata[disp_pkg::ST_EMPTY] = !pop_valid;
        d.hrdata[disp_pkg::ST_DOUT]  = q.dout2;
      end
    end

    // Serial sequencer: half-period timer paces every edge
    if (q.timer != '0)
    begin
      d.timer = q.timer - 1'b1;
    end
    unique case (q.st)
      S_IDLE:
      begin
        d.ce_n = 1'b1;
      end
      S_SELECT:
      begin
        // Select line settled, now lower chip enable
        if (q.timer == '0)
        begin
          d.ce_n  = 1'b0;
          d.st    = S_LOW;
          d.timer = TW'(HALF_CYC);
        end
      end
      S_LOW:
      begin
        if (q.wbits == '0)
        begin
          pop_ready = 1'b1;
          if (pop_valid)
          begin
            d.word  = pop_data;
            d.wbits = disp_pkg::WORD_BITS;
            d.sdata = pop_data[31];
            d.timer = TW'(HALF_CYC);
          end
        end
        else if (q.timer == '0)
        begin
          d.sclk  = 1'b1;
          d.st    = S_HIGH;
          d.timer = TW'(HALF_CYC);
        end
      end
      S_HIGH:
      begin
        if (q.timer == '0)
        begin
          d.sclk  = 1'b0;
          d.word  = {q.word[30:0], 1'b0};
          d.sdata = q.word[30];
          d.wbits = q.wbits - 1'b1;
          d.left  = q.left - 1'b1;
          d.timer = TW'(HALF_CYC);
          d.st    = S_LOW;
          if (q.left == disp_pkg::CNT_W'(1))
          begin
            d.ce_n = 1'b1;
            d.st   = S_END;
          end
        end
      end
      S_END:
      begin
        // Clock low, chip enable high: display latches
        if (q.timer == '0)
        begin
          d.wbits = '0;
          d.sdata = 1'b0;
          d.st    = S_IDLE;
        end
      end
      default:
      begin
        d.st = S_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q        <= '0;
      q.st     <= S_IDLE;
      q.hready <= 1'b1;
      q.ce_n   <= 1'b1;
      q.rst    <= 1'b1;
    end
    else if (clk_en)
    begin
      q <= d;
    end
  end
endmodule // display_host

// [logic/word_fifo.sv]
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clk_en,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || WIDTH < 1)
  begin : g_bad
    $error("word_fifo needs DEPTH of two or more");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               rd;
    logic [PW-1:0]               wr;
    logic [PW:0]                 cnt;
  } fifo_t;

  fifo_t q;
  fifo_t d;
  logic  push;
  logic  pop;

  assign in_ready  = (q.cnt != (PW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd];

  // Pointer and count update
  always_comb
  begin
    d    = q;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push)
    begin
      d.mem[q.wr] = in_data;
      d.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (pop)
    begin
      d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
    end
    if (push && !pop)
    begin
      d.cnt = q.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
    end
    else if (clk_en)
    begin
      q <= d;
    end
  end
endmodule // word_fifo

// [tb/disp_sva.sv]
`timescale 1ns/1ps
module disp_sva (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Serial bus
  input wire logic        chip_enable_n,
  input wire logic        register_select,
  input wire logic        serial_clk,
  input wire logic        serial_data,
  // Row sinks
  input wire logic [15:0] row_drive
);
  // --------
  // Checks
  // --------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  one_row_a: assert property
    ($onehot0(row_drive[7:0]) && $onehot0(row_drive[15:8]))
    else $error("two rows lit in one IC");
  blank_gap_a: assert property
    ($fell(|row_drive[7:0]) |=> !(|row_drive[7:0]) [*8])
    else $error("row gap too short");
  sel_low_a: assert property
    ($fell(chip_enable_n) |-> !serial_clk && $stable(register_select))
    else $error("select with clock high");
  clk_sel_a: assert property
    (serial_clk |-> !chip_enable_n)
    else $error("clock outside select");
  data_hold_a: assert property
    ($rose(serial_clk) |-> $stable(serial_data))
    else $error("data moved at clock rise");
  clk_high_a: assert property
    ($rose(serial_clk) |=> serial_clk [*5] ##1 !serial_clk)
    else $error("clock high time wrong");
  latch_low_a: assert property
    ($rose(chip_enable_n) |-> !serial_clk)
    else $error("deselect with clock high");
  rs_hold_a: assert property
    (!chip_enable_n |-> $stable(register_select))
    else $error("select line moved in load");
endmodule // disp_sva

// [tb/test_led_matrix_refresh_cascade.sv]
`timescale 1ns/1ps
module test_led_matrix_refresh_cascade;
  // --------
  // Bench state
  // --------
  logic        hclk;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic [15:0] row_drive;
  logic [39:0] col_drive;
  logic [3:0]  peak_code;
  logic [13:0] brightness_pct;
  logic [31:0] rd;
  logic [31:0] words [10];
  logic [7:0]  cw [2];
  logic        e;
  logic        clk_en = 1'b1;
  logic        osc_out;
  logic [16:0] snap_row;
  logic [39:0] snap_col;
  int          miscompares = 0;
  int          compares = 0;
  int          seed = 32'h82db_32e3;
  int          dot;

  // Both ends joined by the bus
  disp_bus_if disp_bus_if_inst ();
  display_host display_host_inst (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .bus(disp_bus_if_inst.host));
  // Internal oscillator only; no external source needs its range kept
  display_end #(.OSC_CYC(4)) display_end_inst (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .bus(disp_bus_if_inst.display),
    .osc_ext_in(1'b0), .osc_use_ext(1'b0), .osc_out(osc_out), .row_drive(row_drive),
    .col_drive(col_drive), .peak_code(peak_code), .brightness_pct(brightness_pct));
  disp_sva disp_sva_inst (
    .hclk(hclk), .hresetn(hresetn), .chip_enable_n(disp_bus_if_inst.chip_enable_n),
    .register_select(disp_bus_if_inst.register_select), .row_drive(row_drive),
    .serial_clk(disp_bus_if_inst.serial_clk), .serial_data(disp_bus_if_inst.serial_data));

  // Clock
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Watchdog
  initial
  begin
    repeat (40000) @(posedge hclk);
    miscompares++;
    results();
  end

  // --------
  // Tasks
  // --------
  task automatic chk(input string n, input logic [39:0] x, input logic [39:0] g);
    compares++;
    if (g !== x)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask

  // One AHB single transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic go(input logic [31:0] c, input logic [31:0] n);
    xfer(1'b1, disp_pkg::REG_COUNT, n, rd);
    xfer(1'b1, disp_pkg::REG_CTRL, c, rd);
  endtask

  task automatic idle();
    do xfer(1'b0, disp_pkg::REG_STATUS, 32'h0, rd); while (rd[0] !== 1'b0);
  endtask

  task results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // --------
  // Main sequence
  // --------
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, disp_pkg::REG_CTRL, 32'h0, rd);
    chk("ctrl", 40'h8, 40'(rd));
    xfer(1'b0, disp_pkg::REG_STATUS, 32'h0, rd);
    chk("status", 40'h4, 40'(rd[2:0]));
    xfer(1'b0, 8'h10, 32'h0, rd);
    chk("unmapped", 40'h0, 40'(rd));
    xfer(1'b1, disp_pkg::REG_CTRL, 32'h0, rd);
    // Dot load while the FIFO runs full
    for (int k = 0; k < 10; k++)
      words[k] = $random(seed);
    go(32'h1, 32'h140);
    for (int k = 0; k < 10; k++)
    begin
      if (k == 9)
      begin
        xfer(1'b0, disp_pkg::REG_STATUS, 32'h0, rd);
        chk("full", 40'h3, 40'(rd[1:0]));
      end
      xfer(1'b1, disp_pkg::REG_DATA, words[k], rd);
    end
    idle();
    chk("empty", 40'h4, 40'(rd[2:0]));
    // Control words, one IC put to sleep on pass two
    for (int i = 0; i < 4; i++)
    begin
      cw[0] = 8'h40 | (8'($random(seed)) & 8'h3f);
      cw[1] = (i == 2) ? 8'h0d : cw[0] ^ 8'h1a;
      if (i == 0)
        cw = '{8'h4d, 8'h4d};
      if (i == 3)
        cw = '{8'h4f, 8'h4f};
      go(32'h3, 32'h10);
      xfer(1'b1, disp_pkg::REG_DATA, {cw[1], cw[0], 16'h0}, rd);
      idle();
      repeat (20) @(posedge hclk);
      for (int r = 0; r < 2; r++)
      begin
        chk("peak", 40'(cw[r][5:4]), 40'(peak_code[r*2+:2]));
        dot = disp_pkg::PEAK_PCT[cw[r][5:4]] * disp_pkg::PWM_ON[cw[r][3:0]] / 60;
        if (cw[r][6])
          chk("bright", 40'(dot), 40'(brightness_pct[r*7+:7]));
        else
          chk("asleep", 40'h0, 40'(row_drive[r*8+:8]));
      end
    end
    // Simultaneous mode: word 1 first, then one 8-bit load for both ICs
    go(32'h3, 32'h10);
    xfer(1'b1, disp_pkg::REG_DATA, 32'h8181_0000, rd);
    idle();
    cw[0] = 8'h4e | (8'($random(seed)) & 8'h31);
    cw[1] = cw[0];
    go(32'h3, 32'h8);
    xfer(1'b1, disp_pkg::REG_DATA, {cw[0], 24'h0}, rd);
    idle();
    chk("dout", 40'(cw[0][0]), 40'(rd[3]));
    repeat (20) @(posedge hclk);
    for (int r = 0; r < 2; r++)
      chk("simul", 40'(cw[r][5:4]), 40'(peak_code[r*2+:2]));
    // Square wave for slaves, half high
    dot = 0;
    repeat (40) @(negedge hclk) dot += osc_out;
    chk("osc", 40'd20, 40'(dot));
    // Clock enable low freezes both ends
    @(posedge hclk);
    clk_en <= 1'b0;
    @(negedge hclk);
    snap_row = {osc_out, row_drive};
    snap_col = col_drive;
    repeat (50) @(negedge hclk) chk("frozen", 40'(snap_row), 40'({osc_out, row_drive}));
    chk("frozen cols", snap_col, col_drive);
    @(posedge hclk);
    clk_en <= 1'b1;
    // Blanking
    xfer(1'b1, disp_pkg::REG_CTRL, 32'h4, rd);
    repeat (20) @(posedge hclk);
    chk("blank", 40'h0, 40'(row_drive));
    xfer(1'b1, disp_pkg::REG_CTRL, 32'h0, rd);
    // Pixel map over a frame, kept through sleep
    for (int s = 0; s < 400; s++)
    begin
      repeat (5) @(negedge hclk);
      for (int r = 0; r < 16; r++)
      begin
        for (int c = 0; c < 20 && row_drive[r] === 1'b1; c++)
        begin
          dot = r / 8 * 160 + c * 8 + r % 8;
          e = words[dot/32][31-dot%32];
          chk("pixel", 40'(e), 40'(col_drive[r/8*20+c]));
        end
      end
    end
    results();
  end
endmodule // test_led_matrix_refresh_cascade
